// file: rtl/enc_pkg.sv
// What this block does
// - Four bus slaves together carry the 13-bit single-turn position.
// - Only slave A parameter bits configure; B, C, D parameter writes ignored.
// - P0: 0 Gray, 1 binary. P2: 0 count down clockwise, 1 up. P3 unused.
// - P1: 1 returns position without flags, 0 returns a flag in each slave.
// - Slave A takes output data; B, C, D output data is disregarded.
// - D2/D3 change 01 to 10 or 10 to 01 stores current position.
// - D0/D1 equal 01 presets position to a quarter turn.
// - D0/D1 equal 10 presets position to zero.
// - No-flag layout: bits 0-12 over A, B, C nibbles then D bit 0.
// - Flag layout: three position bits on D0-D2, flag on D3, every slave.
// - Master alternates D2 each cycle; each slave returns its sample's D2 as flag.
// - With flags the usable width drops from 13 to 12 bits.
// - Command seen at once by slave A; B to D show it next read cycle.
package enc_pkg;

    // ----------------------------------------
    // Widths
    // ----------------------------------------
    localparam int POS_W = 13;
    localparam int FLAG_POS_W = 12;
    localparam int NIB_W = 4;
    localparam int SLAVES = 4;
    localparam int ADDR_W = 4;
    localparam int BITS_PER_FLAG_NIB = 3;

    // ----------------------------------------
    // Register map (one nibble per offset)
    // ----------------------------------------
    localparam logic [3:0] SLV_IN_BASE = 4'h0;
    localparam logic [3:0] SLV_OUT_BASE = 4'h4;
    localparam logic [3:0] SLV_PAR_BASE = 4'h8;
    localparam logic [1:0] SLAVE_A = 2'h0;
    localparam logic [1:0] SLAVE_D = 2'h3;

    // ----------------------------------------
    // Command pairs, written {first bit, second bit}
    // ----------------------------------------
    localparam logic [1:0] PAIR_01 = 2'h1;
    localparam logic [1:0] PAIR_10 = 2'h2;
    localparam logic [12:0] QUARTER_POS = 13'h0800;
    localparam logic [12:0] ZERO_POS = 13'h0000;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [3:0] CFG_RST = 4'hF;
    localparam logic [3:0] OUT_RST = 4'h0;
    localparam logic [12:0] OFFSET_RST = 13'h0000;

    typedef struct packed {
        logic p3;
        logic p2;
        logic p1;
        logic p0;
    } cfg_t;

    typedef struct packed {
        logic d3;
        logic d2;
        logic d1;
        logic d0;
    } slave_out_t;

endpackage

// file: rtl/sample_mem.sv
`timescale 1ns/100ps
`default_nettype none
module sample_mem #(
    parameter int WORDS = 4,
    parameter int W = 4
) (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic load,
    input wire logic [WORDS*W-1:0] load_data,
    input wire logic rd,
    input wire logic [$clog2(WORDS)-1:0] rd_idx,
    output logic [W-1:0] rd_q
);

    logic [W-1:0] mem_r [WORDS];

    // ----------------------------------------
    // Whole sample loads in one edge
    // ----------------------------------------
    // All words change together so no reader ever sees a half-updated sample.
    genvar k;
    generate
        for (k = 0; k < WORDS; k++) begin : g_word
            always_ff @(posedge ref_clk or negedge rst_n) begin
                if (!rst_n) begin
                    mem_r[k] <= '0;
                end else if (load) begin
                    mem_r[k] <= load_data[k*W +: W];
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Registered read, zero when idle
    // ----------------------------------------
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= '0;
        end else begin
            rd_q <= rd ? mem_r[rd_idx] : '0;
        end
    end

endmodule
`default_nettype wire

// file: rtl/abs_encoder_slaves.sv
`timescale 1ns/100ps
`default_nettype none
module abs_encoder_slaves (
    input wire logic ref_clk,
    input wire logic rst_n,
    input wire logic [3:0] reg_addr,
    input wire logic [3:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [3:0] reg_rdata,
    input wire logic [12:0] pos_count,
    output var enc_pkg::cfg_t cfg_q,
    output logic [12:0] position,
    output logic stored_flag
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------
    function automatic logic in_region(input logic [3:0] addr, input logic [3:0] base);
        in_region = (addr[3:2] == base[3:2]);
    endfunction

    function automatic logic is_toggle_pair(input logic [1:0] from_p, input logic [1:0] to_p);
        is_toggle_pair = ((from_p == enc_pkg::PAIR_01) && (to_p == enc_pkg::PAIR_10)) ||
                         ((from_p == enc_pkg::PAIR_10) && (to_p == enc_pkg::PAIR_01));
    endfunction

    wire logic is_slave_a;
    wire logic wr_out_a;
    wire logic wr_out_other;
    wire logic wr_par_a;
    wire logic wr_par_other;
    wire logic rd_in;

    assign is_slave_a = (reg_addr[1:0] == enc_pkg::SLAVE_A);
    assign wr_out_a = reg_wr && in_region(reg_addr, enc_pkg::SLV_OUT_BASE) && is_slave_a;
    assign wr_out_other = reg_wr && in_region(reg_addr, enc_pkg::SLV_OUT_BASE) && !is_slave_a;
    assign wr_par_a = reg_wr && in_region(reg_addr, enc_pkg::SLV_PAR_BASE) && is_slave_a;
    assign wr_par_other = reg_wr && in_region(reg_addr, enc_pkg::SLV_PAR_BASE) && !is_slave_a;
    assign rd_in = reg_rd && in_region(reg_addr, enc_pkg::SLV_IN_BASE);

    // ----------------------------------------
    // Slave A parameter and output data
    // ----------------------------------------
    enc_pkg::cfg_t cfg_r;
    enc_pkg::slave_out_t out_r;
    enc_pkg::slave_out_t new_out;

    assign new_out = enc_pkg::slave_out_t'(reg_wdata);

    // Parameter bits of B to D and output data of B to D fall on the floor
    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_r <= enc_pkg::cfg_t'(enc_pkg::CFG_RST);
        end else if (wr_par_a) begin
            cfg_r <= enc_pkg::cfg_t'(reg_wdata);
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            out_r <= enc_pkg::slave_out_t'(enc_pkg::OUT_RST);
        end else if (wr_out_a) begin
            out_r <= new_out;
        end
    end

    // ----------------------------------------
    // Command decode from slave A output data
    // ----------------------------------------
    wire logic [1:0] preset_pair;
    wire logic [1:0] store_pair_old;
    wire logic [1:0] store_pair_new;
    wire logic preset_quarter;
    wire logic preset_zero;
    wire logic preset_any;
    wire logic store_evt;
    wire logic store_hold;
    wire logic flag_toggle;

    assign preset_pair = {new_out.d0, new_out.d1};
    assign store_pair_old = {out_r.d2, out_r.d3};
    assign store_pair_new = {new_out.d2, new_out.d3};
    assign preset_quarter = wr_out_a && (preset_pair == enc_pkg::PAIR_01);
    assign preset_zero = wr_out_a && (preset_pair == enc_pkg::PAIR_10);
    assign preset_any = preset_quarter || preset_zero;
    assign store_evt = wr_out_a && is_toggle_pair(store_pair_old, store_pair_new);
    // Pairs 01 and 10 keep the stored sample frozen; 00 and 11 let it track
    assign store_hold = (store_pair_new == enc_pkg::PAIR_01) || (store_pair_new == enc_pkg::PAIR_10);
    assign flag_toggle = wr_out_a && (new_out.d2 != out_r.d2);

    // ----------------------------------------
    // Position with direction and preset
    // ----------------------------------------
    logic [12:0] offset_r;
    wire logic [12:0] dir_pos;
    wire logic [12:0] live_pos;
    wire logic [12:0] preset_target;
    wire logic [12:0] word_pos;
    wire logic [12:0] offset_nxt;

    // P3 is not decoded anywhere
    assign dir_pos = cfg_r.p2 ? pos_count : (13'h0000 - pos_count);
    assign live_pos = dir_pos + offset_r;
    assign preset_target = preset_quarter ? enc_pkg::QUARTER_POS : enc_pkg::ZERO_POS;
    // Offset absorbs the sensed angle so the preset holds as the shaft turns
    assign offset_nxt = preset_any ? (preset_target - dir_pos) : offset_r;
    // The word stored with a preset already carries the preset value
    assign word_pos = preset_any ? preset_target : live_pos;

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            offset_r <= enc_pkg::OFFSET_RST;
        end else begin
            offset_r <= offset_nxt;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            position <= enc_pkg::ZERO_POS;
        end else begin
            position <= live_pos;
        end
    end

    // ----------------------------------------
    // Output code and nibble layout
    // ----------------------------------------
    wire logic [12:0] code13;
    wire logic [11:0] pos12;
    wire logic [11:0] code12;
    wire logic flag_val;
    wire logic [15:0] sample_plain;
    wire logic [15:0] sample_flag;
    wire logic [15:0] sample_word;

    assign code13 = cfg_r.p0 ? word_pos : (word_pos ^ (word_pos >> 1));
    // Flag format drops the finest bit so Gray stays a true single-step code
    assign pos12 = word_pos[12:1];
    assign code12 = cfg_r.p0 ? pos12 : (pos12 ^ (pos12 >> 1));
    assign flag_val = new_out.d2;

    assign sample_plain = {3'h0, code13};

    genvar n;
    generate
        for (n = 0; n < enc_pkg::SLAVES; n++) begin : g_flag_nib
            assign sample_flag[n*enc_pkg::NIB_W +: enc_pkg::NIB_W] =
                {flag_val, code12[n*enc_pkg::BITS_PER_FLAG_NIB +: enc_pkg::BITS_PER_FLAG_NIB]};
        end
    endgenerate

    assign sample_word = cfg_r.p1 ? sample_plain : sample_flag;

    // ----------------------------------------
    // Sample latch serving all four slaves
    // ----------------------------------------
    // The latch is only refreshed by a slave A write, so slaves polled before
    // slave A in a bus cycle keep the previous sample until the next cycle.
    wire logic load;
    logic sample_flag_r;

    assign load = wr_out_a && (preset_any || (cfg_r.p1 ? (store_evt || !store_hold) : flag_toggle));

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            stored_flag <= 1'b0;
        end else if (load) begin
            stored_flag <= flag_val;
        end
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            sample_flag_r <= 1'b0;
        end else if (load) begin
            sample_flag_r <= !cfg_r.p1;
        end
    end

    sample_mem #(
        .WORDS(enc_pkg::SLAVES),
        .W(enc_pkg::NIB_W)
    ) u_sample (
        .ref_clk(ref_clk),
        .rst_n(rst_n),
        .load(load),
        .load_data(sample_word),
        .rd(rd_in),
        .rd_idx(reg_addr[1:0]),
        .rd_q(reg_rdata)
    );

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            cfg_q <= enc_pkg::cfg_t'(enc_pkg::CFG_RST);
        end else begin
            cfg_q <= cfg_r;
        end
    end

    // ----------------------------------------
    // Shadow of the served sample
    // ----------------------------------------
    // Only the checks read this copy; it lets them see every nibble that a
    // slave read must return without reaching into the memory module.
    logic [15:0] shadow_word_r;
    wire logic [11:0] shadow_payload;

    // Position bits of the flag format with the four flags stripped out
    assign shadow_payload = {shadow_word_r[14:12], shadow_word_r[10:8], shadow_word_r[6:4], shadow_word_r[2:0]};

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            shadow_word_r <= 16'h0000;
        end else if (load) begin
            shadow_word_r <= sample_word;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_n);

    par_ignore_a: assert property (wr_par_other && !wr_par_a |=> cfg_r == $past(cfg_r))
        else $error("parameter write to slave B-D changed configuration");

    out_ignore_a: assert property (wr_out_other |=> out_r == $past(out_r))
        else $error("output write to slave B-D changed command state");

    preset_quarter_a: assert property (preset_quarter |=> 13'(offset_r + $past(dir_pos)) == enc_pkg::QUARTER_POS)
        else $error("quarter preset offset wrong");

    preset_zero_a: assert property (preset_zero |=> 13'(offset_r + $past(dir_pos)) == enc_pkg::ZERO_POS)
        else $error("zero preset offset wrong");

    store_hold_a: assert property (cfg_r.p1 && wr_out_a && !preset_any && store_hold
        && (store_pair_new == store_pair_old) |-> !load)
        else $error("held store pair reloaded sample");

    flag_return_a: assert property (rd_in && sample_flag_r && !load |=> reg_rdata[3] == stored_flag)
        else $error("flag bit does not match stored sample");

    flag_toggle_a: assert property (!cfg_r.p1 && flag_toggle |=> stored_flag == $past(reg_wdata[2]) ##1 sample_flag_r)
        else $error("flag toggle did not latch a new sample");

    plain_top_a: assert property (rd_in && (reg_addr[1:0] == enc_pkg::SLAVE_D) && !sample_flag_r
        && !load |=> reg_rdata[3:1] == 3'h0)
        else $error("slave D unused bits not zero");

    idle_read_a: assert property (!rd_in |=> reg_rdata == 4'h0)
        else $error("read data present without a slave input read");

    // ----------------------------------------
    // Configuration, position and served word
    // ----------------------------------------
    // The layout checks look at the word as it is latched, so a layout slip shows at the
    // load itself rather than only when a slave happens to be read.
    cfg_mirror_a: assert property (cfg_q == $past(cfg_r))
        else $error("configuration copy is not one cycle behind");

    par_take_a: assert property (wr_par_a |=> 4'(cfg_r) == $past(reg_wdata))
        else $error("slave A parameter write not taken");

    out_take_a: assert property (wr_out_a |=> out_r == $past(new_out))
        else $error("slave A output write not taken");

    offset_keep_a: assert property (!preset_any |=> offset_r == $past(offset_r))
        else $error("position offset moved without a preset");

    count_up_a: assert property (cfg_r.p2 |=>
        position == 13'($past(pos_count) + $past(offset_r)))
        else $error("up-counting position wrong");

    count_down_a: assert property (!cfg_r.p2 |=>
        13'(position + $past(pos_count)) == $past(offset_r))
        else $error("down-counting position wrong");

    preset_load_a: assert property (preset_any |-> load)
        else $error("preset did not refresh the served sample");

    store_load_a: assert property (cfg_r.p1 && store_evt |-> load)
        else $error("store command did not latch the position");

    track_load_a: assert property (cfg_r.p1 && wr_out_a && !store_hold |-> load)
        else $error("neutral store pair did not follow the position");

    store_freeze_a: assert property (cfg_r.p1 && wr_out_a && !preset_any && store_hold
        && !store_evt |-> !load)
        else $error("held store pair refreshed the sample");

    flag_keep_a: assert property (!cfg_r.p1 && wr_out_a && !preset_any
        && (new_out.d2 == out_r.d2) |-> !load)
        else $error("flag sample refreshed without a flag change");

    flag_stable_a: assert property (!load |=>
        stored_flag == $past(stored_flag) && sample_flag_r == $past(sample_flag_r))
        else $error("served sample flags changed without a load");

    read_nibble_a: assert property (rd_in |=>
        reg_rdata == $past(shadow_word_r[{reg_addr[1:0], 2'b00} +: 4]))
        else $error("slave read did not return its nibble of the served sample");

    binary_plain_a: assert property (load && cfg_r.p1 && cfg_r.p0 |=>
        shadow_word_r == {3'h0, $past(word_pos)})
        else $error("binary word without flags laid out wrong");

    gray_plain_a: assert property (load && cfg_r.p1 && !cfg_r.p0 |=>
        shadow_word_r[15:13] == 3'h0 && (shadow_word_r[12:0] ^ $past(word_pos)) == ($past(word_pos) >> 1))
        else $error("Gray word without flags laid out wrong");

    binary_flag_a: assert property (load && !cfg_r.p1 && cfg_r.p0 |=>
        shadow_payload == $past(word_pos[12:1]))
        else $error("binary word with flags laid out wrong");

    gray_flag_a: assert property (load && !cfg_r.p1 && !cfg_r.p0 |=>
        (shadow_payload ^ $past(word_pos[12:1])) == ($past(word_pos[12:1]) >> 1))
        else $error("Gray word with flags laid out wrong");

    flag_bits_a: assert property (sample_flag_r |->
        shadow_word_r[15] == stored_flag && shadow_word_r[11] == stored_flag
        && shadow_word_r[7] == stored_flag && shadow_word_r[3] == stored_flag)
        else $error("flag bits of the served sample differ");

    plain_pad_a: assert property (!sample_flag_r |-> shadow_word_r[15:13] == 3'h0)
        else $error("unused slave D bits of a word without flags not zero");

    zero_word_a: assert property (preset_zero && cfg_r.p1 && cfg_r.p0 |=> shadow_word_r == 16'h0000)
        else $error("zero preset not served as a zero word");

    quarter_word_a: assert property (preset_quarter && cfg_r.p1 && cfg_r.p0 |=>
        shadow_word_r == {3'h0, enc_pkg::QUARTER_POS})
        else $error("quarter preset not served as a quarter turn");

endmodule
`default_nettype wire

// file: sim/asi_master_model.sv
`timescale 1ns/100ps
`default_nettype none
module asi_master_model (
    input wire logic ref_clk,
    input wire logic [3:0] reg_rdata,
    output logic [3:0] reg_addr,
    output logic [3:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd
);
    initial begin
        reg_addr = 4'h0;
        reg_wdata = 4'h0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end

    task automatic wr(input logic [3:0] a, input logic [3:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask

    // Answer stands only in the cycle after the taking edge
    task automatic rd(input logic [3:0] a, output logic [3:0] q);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask

    // Ascending distinct slots keep the four reads of one word close together
    task automatic poll(output logic [15:0] w);
        logic [3:0] q;
        for (int k = 0; k < 4; k++) begin
            rd(4'(enc_pkg::SLV_IN_BASE + 4'(k)), q);
            w[4*k+:4] = q;
        end
    endtask
endmodule
`default_nettype wire

// file: sim/test_absolute_encoder_four_slave_port.sv
`timescale 1ns/100ps
`default_nettype none
module test_absolute_encoder_four_slave_port;
    logic ref_clk, rst_n, reg_wr, reg_rd, stored_flag;
    logic [3:0] reg_addr, reg_wdata, reg_rdata, cfg, q;
    logic [12:0] pos_count, position, p;
    logic [15:0] w;
    enc_pkg::cfg_t cfg_q;
    int fails, n_compared;

    abs_encoder_slaves abs_encoder_slaves_inst (.ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .pos_count(pos_count), .cfg_q(cfg_q), .position(position), .stored_flag(stored_flag));
    asi_master_model asi_master_model_inst (.ref_clk(ref_clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd));

    // ----------------------------------------
    // Expectations and reporting
    // ----------------------------------------
    function automatic logic [15:0] exp_word(input logic [12:0] p, input logic [3:0] c, input logic f);
        logic [12:0] g;
        logic [11:0] v;
        g = c[0] ? p : p ^ (p >> 1);
        v = c[0] ? p[12:1] : p[12:1] ^ (p[12:1] >> 1);
        if (c[1])
            return {3'h0, g};
        return {f, v[11:9], f, v[8:6], f, v[5:3], f, v[2:0]};
    endfunction

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fails++;
            $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask

    task automatic set_pos(input logic [12:0] v);
        @(posedge ref_clk);
        pos_count <= v;
        repeat (2) @(posedge ref_clk);
    endtask

    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // ----------------------------------------
    // Stimulus
    // ----------------------------------------
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end

    initial begin
        #500us;
        fails++;
        tally_and_finish();
    end

    initial begin
        rst_n = 1'b0;
        pos_count = 13'h0000;
        fails = 0;
        n_compared = 0;
        void'($urandom(32'h1FD5));
        repeat (6) @(posedge ref_clk);
        #2 rst_n = 1'b1;
        check(16'(cfg_q), 16'h000F);
        check(16'(position), 16'h0000);
        check({11'h000, reg_rdata, stored_flag}, 16'h0000);
        $display("test reset done");
        // P3 from loop bit 1, Gray and binary, live tracking pairs 00 and 11
        for (int i = 0; i < 12; i++) begin
            p = 13'($urandom);
            cfg = {i[1], 2'b11, i[0]};
            asi_master_model_inst.wr(enc_pkg::SLV_PAR_BASE, cfg);
            asi_master_model_inst.wr(4'h9, 4'h0);
            set_pos(p);
            asi_master_model_inst.wr(enc_pkg::SLV_OUT_BASE, {i[1], i[1], 2'b00});
            asi_master_model_inst.poll(w);
            check(w, exp_word(p, cfg, 1'b0));
            check(16'(cfg_q), 16'(cfg));
        end
        $display("test layout done");
        p = 13'($urandom);
        set_pos(p);
        asi_master_model_inst.wr(4'h4, 4'h0);
        asi_master_model_inst.wr(4'h4, 4'h4);
        set_pos(p ^ 13'h1555);
        asi_master_model_inst.wr(4'h4, 4'h4);
        asi_master_model_inst.poll(w);
        check(w, exp_word(p, cfg, 1'b0));
        asi_master_model_inst.wr(4'h4, 4'h8);
        asi_master_model_inst.poll(w);
        check(w, exp_word(p ^ 13'h1555, cfg, 1'b0));
        $display("test store done");
        // Gray and binary both carried in the flag format
        for (int i = 0; i < 6; i++) begin
            cfg = {3'b010, i[1]};
            asi_master_model_inst.wr(enc_pkg::SLV_PAR_BASE, cfg);
            p = 13'($urandom);
            set_pos(p);
            asi_master_model_inst.wr(4'h4, {1'b0, ~i[0], 2'b00});
            set_pos(13'($urandom));
            asi_master_model_inst.poll(w);
            check(w, exp_word(p, cfg, ~i[0]));
            check({15'h0000, stored_flag}, {15'h0000, ~i[0]});
            check({12'h000, w[15], w[11], w[7], w[3]}, {12'h000, {4{~i[0]}}});
        end
        $display("test flags done");
        asi_master_model_inst.wr(enc_pkg::SLV_PAR_BASE, 4'hF);
        asi_master_model_inst.wr(4'h5, 4'h1);
        set_pos(p);
        check(16'(position), 16'(p));
        asi_master_model_inst.wr(4'h4, 4'h1);
        set_pos(p + 13'h0007);
        check(16'(position), 16'h0007);
        asi_master_model_inst.wr(4'h4, 4'h2);
        set_pos(p + 13'h000A);
        check(16'(position), 16'h0803);
        asi_master_model_inst.wr(enc_pkg::SLV_PAR_BASE, 4'hB);
        asi_master_model_inst.wr(4'h4, 4'h1);
        set_pos(p + 13'h000F);
        check(16'(position), 16'h1FFB);
        $display("test preset done");
        // Slave B read before the slave A write still shows the older sample
        asi_master_model_inst.rd(4'h1, q);
        check({12'h000, q}, 16'h0000);
        asi_master_model_inst.wr(enc_pkg::SLV_OUT_BASE, 4'h0);
        asi_master_model_inst.rd(4'h1, q);
        w = exp_word(13'h1FFB, 4'hB, 1'b0);
        check({12'h000, q}, {12'h000, w[7:4]});
        $display("test order done");
        asi_master_model_inst.rd(4'hC, q);
        check(16'(q), 16'h0000);
        asi_master_model_inst.rd(4'h4, q);
        check(16'(q), 16'h0000);
        asi_master_model_inst.rd(4'h0, q);
        @(posedge ref_clk);
        #1 check(16'(reg_rdata), 16'h0000);
        $display("test refused done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
